// ==== rtl/tdcreg_regs.svh ====
// offsets, field positions, reset values and timing counts of the control bank
// assumes a byte address on a 16-bit register port
`ifndef TDCREG_REGS_SVH
`define TDCREG_REGS_SVH
`define TDCREG_OFF_SW_CLEAR 16'h1016
`define TDCREG_OFF_EV_RESET 16'h1018
`define TDCREG_OFF_SW_TRIG 16'h101A
`define TDCREG_OFF_TRIG_CNT_HI 16'h101C
`define TDCREG_OFF_TRIG_CNT_LO 16'h101E
`define TDCREG_OFF_EV_STORED 16'h1020
`define TDCREG_OFF_THRESH 16'h1022
`define TDCREG_OFF_BLT_NUM 16'h1024
`define TDCREG_OFF_FW_REV 16'h1026
`define TDCREG_OFF_TEST_HI 16'h1028
`define TDCREG_OFF_TEST_LO 16'h102A
`define TDCREG_OFF_OUT_SEL 16'h102C
`define TDCREG_OFF_MICRO 16'h102E
`define TDCREG_OFF_MICRO_HS 16'h1030
`define TDCREG_OFF_FLASH_CS 16'h1032
`define TDCREG_OFF_FLASH_DATA 16'h1034
`define TDCREG_OFF_COMP_PAGE 16'h1036
`define TDCREG_OFF_EVF_HI 16'h1038
`define TDCREG_OFF_EVF_LO 16'h103A
`define TDCREG_OFF_EVF_LEVEL 16'h103C
`define TDCREG_OFF_EVF_FLAGS 16'h103E
`define TDCREG_OFF_SCRATCH_HI 16'h1200
`define TDCREG_OFF_SCRATCH_LO 16'h1202
`define TDCREG_OFF_SCRATCH_N 16'h1204
`define TDCREG_OFF_COMP_LO 16'h8000
`define TDCREG_OFF_COMP_HI 16'h81FE
`define TDCREG_RST_THRESH 15'h0040
`define TDCREG_MAX_THRESH 15'h7FDF
`define TDCREG_RST_BLT 8'h00
`define TDCREG_RST_PAGE 8'h00
`define TDCREG_RST_CS 1'b1
`define TDCREG_BIT_HS_READ 0
`define TDCREG_BIT_HS_WRITE 1
`define TDCREG_BIT_EVF_READY 0
`define TDCREG_BIT_EVF_FULL 1
`define TDCREG_EVF_DEPTH 11'h400
`define TDCREG_FLASH_PAGES 12'h800
`define TDCREG_FLASH_PAGE_BYTES 9'h108
`define TDCREG_FLASH_USED_BYTES 9'h100
`define TDCREG_LUT_100PS 9'h100
`define TDCREG_LUT_200PS 9'h080
`define TDCREG_SCK_HALF_NS 100
`define TDCREG_CLK_NS 50
`define TDCREG_SCK_HALF_CYC ((`TDCREG_SCK_HALF_NS + `TDCREG_CLK_NS - 1) / `TDCREG_CLK_NS)
`endif

// ==== rtl/tdcreg_pkg.sv ====
// types shared by the control bank and its helpers
// assumes nothing beyond the regs header for numbers
package tdcreg_pkg;
   typedef enum logic [2:0] {
      TDCREG_SPI_IDLE = 3'b001,
      TDCREG_SPI_LOW = 3'b010,
      TDCREG_SPI_HIGH = 3'b100
   } tdcreg_spi_state_t;
   typedef logic [15:0] tdcreg_word_t;
endpackage

// ==== rtl/tdcreg_spi_byte.sv ====
// one serial byte exchange with the flash, msb first
// assumes a flash sampling on the rising sck edge
`timescale 1ns/10ps
`include "tdcreg_regs.svh"
module tdcreg_spi_byte import tdcreg_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire logic miso,
   output logic busy,
   output logic sck,
   output logic mosi,
   output logic [7:0] rx_byte
);
   localparam logic [3:0] HALF = 4'(`TDCREG_SCK_HALF_CYC);
   typedef struct packed {
      tdcreg_spi_state_t st;
      logic [3:0] div;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic [7:0] rx;
   } tdcreg_spi_t;
   tdcreg_spi_t s_reg, s_next;
   always_comb begin
      s_next = s_reg;
      unique case (s_reg.st)
         TDCREG_SPI_IDLE: begin
            if (start) begin
               s_next.st = TDCREG_SPI_LOW;
               s_next.sh = tx_byte;
               s_next.bitn = 3'h7;
               s_next.div = HALF;
            end
         end
         TDCREG_SPI_LOW: begin
            s_next.div = s_reg.div - 4'h1;
            if (s_reg.div == 4'h1) begin
               s_next.st = TDCREG_SPI_HIGH;
               s_next.div = HALF;
            end
         end
         TDCREG_SPI_HIGH: begin
            s_next.div = s_reg.div - 4'h1;
            if (s_reg.div == 4'h1) begin
               s_next.div = HALF;
               s_next.rx = {s_reg.rx[6:0], miso};
               s_next.sh = {s_reg.sh[6:0], 1'b0};
               s_next.bitn = s_reg.bitn - 3'h1;
               s_next.st = (s_reg.bitn == 3'h0) ? TDCREG_SPI_IDLE : TDCREG_SPI_LOW;
            end
         end
         default: s_next.st = TDCREG_SPI_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '{st: TDCREG_SPI_IDLE, div: 4'h0, bitn: 3'h0, sh: 8'h00, rx: 8'h00};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end
   assign busy = (s_reg.st != TDCREG_SPI_IDLE);
   assign sck = (s_reg.st == TDCREG_SPI_HIGH);
   assign mosi = s_reg.sh[7];
   assign rx_byte = s_reg.rx;
endmodule

// ==== rtl/tdcreg_event_fifo.sv ====
// event summary fifo, flip-flop storage indexed by pointers
// assumes callers watch full and empty
`timescale 1ns/10ps
module tdcreg_event_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH_LOG2 = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head,
   output logic [DEPTH_LOG2:0] level,
   output logic empty,
   output logic full
);
   localparam int DEPTH = 1 << DEPTH_LOG2;
   typedef struct packed {
      logic [DEPTH_LOG2-1:0] wp;
      logic [DEPTH_LOG2-1:0] rp;
      logic [DEPTH_LOG2:0] cnt;
   } tdcreg_fifo_t;
   tdcreg_fifo_t f_reg, f_next;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic do_push, do_pop;
   assign empty = (f_reg.cnt == '0);
   assign full = (f_reg.cnt == (DEPTH_LOG2+1)'(DEPTH));
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   always_comb begin
      f_next = f_reg;
      if (flush) begin
         f_next = '0;
      end else begin
         if (do_push) f_next.wp = f_reg.wp + 1'b1;
         if (do_pop) f_next.rp = f_reg.rp + 1'b1;
         f_next.cnt = f_reg.cnt + (DEPTH_LOG2+1)'(do_push) - (DEPTH_LOG2+1)'(do_pop);
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         f_reg <= '0;
      end else if (ce) begin
         f_reg <= f_next;
         if (do_push && !flush) mem_reg[f_reg.wp] <= push_data;
      end
   end
   assign head = mem_reg[f_reg.rp];
   assign level = f_reg.cnt;
endmodule

// ==== rtl/tdcreg_top.sv ====
// control, counting and test register bank of the multihit converter board
// assumes one access per reg_strobe on a 16-bit byte-addressed port;
// wide registers come as two halves, high half first
//
// Summary of operation
// - clear write resets chips, buffer, event counter
// - event reset write pulses chip event reset
// - trigger write acts like a hardware trigger
// - 32-bit trigger count, matching mode only
// - report complete events held in buffer
// - almost-full flag when words reach threshold
// - threshold resets to 64, max 32735
// - 8-bit events per block, zero disables
// - read-only 8-bit firmware revision code
// - test mode pushes written words, blocks converters
// - pass 16-bit opcodes to microcontroller
// - read-ok and write-ok gate command access
// - flash select bit drives active-low select
// - flash data access is one byte exchange
// - page addressing covers 2048 pages of 264
// - 8-bit compensation page select, resets zero
// - compensation window readable when enabled
// - table holds 256 or 128 entries
// - each event pushes counter and size word
// - report summary fifo word level
// - status shows not-empty and full bits
// - board full if buffer or fifo full
// - summary fifo disabled after reset
`timescale 1ns/10ps
`include "tdcreg_regs.svh"
module tdcreg_top import tdcreg_pkg::*; #(
   parameter logic [7:0] FW_REVISION = 8'h12, // arbitrary value
   parameter int FIFO_LOG2 = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // register port
   input wire logic reg_strobe,
   input wire logic reg_write,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   // control bits held elsewhere
   input wire logic trigger_matching,
   input wire logic test_fifo_enable,
   input wire logic read_comp_enable,
   input wire logic event_fifo_enable,
   input wire logic resolution_100ps,
   // converter and buffer side
   input wire logic hw_trigger,
   input wire logic [15:0] buffer_word_count,
   input wire logic [15:0] buffer_event_count,
   input wire logic buffer_full,
   input wire logic event_written,
   input wire logic [15:0] event_word_count,
   output logic tdc_clear,
   output logic tdc_global_reset,
   output logic buffer_clear,
   output logic tdc_event_reset,
   output logic trigger,
   output logic buffer_push,
   output logic [31:0] buffer_push_data,
   output logic converter_data_block,
   output logic almost_full,
   output logic board_full,
   output logic [7:0] events_per_block,
   output logic [15:0] out_select,
   // microcontroller
   output logic [15:0] micro_cmd_data,
   output logic micro_cmd_valid,
   output logic micro_read_taken,
   input wire logic [15:0] micro_reply,
   input wire logic command_read_allowed,
   input wire logic command_write_allowed,
   // serial flash
   output logic flash_cs_n,
   output logic flash_sck,
   output logic flash_mosi,
   input wire logic flash_miso,
   output logic flash_busy,
   // compensation memory
   output logic [15:0] comp_addr,
   input wire logic [15:0] comp_rdata
);
   // ------------------------------
   // state
   // ------------------------------
   typedef struct packed {
      logic [31:0] trig_cnt;
      logic [14:0] thresh;
      logic [7:0] blt;
      logic [15:0] test_hi;
      logic [15:0] out_sel;
      logic [15:0] micro;
      logic cmd_valid;
      logic rd_taken;
      logic cs_n;
      logic [7:0] page;
      logic [15:0] scratch_hi;
      logic [15:0] scratch_lo;
      logic [15:0] scratch_n;
      logic [15:0] evf_lo_hold;
      logic clr;
      logic evrst;
      logic strig;
      logic push;
      logic [31:0] push_data;
      logic [15:0] rdata;
      logic ack;
      logic flash_wait;
      logic [2:0] sync_miso;
      logic miso_q;
   } tdcreg_state_t;
   tdcreg_state_t r_reg, r_next;

   logic wr, rd, evf_pop, evf_empty, evf_full, spi_start, spi_busy;
   logic [31:0] evf_head;
   logic [FIFO_LOG2:0] evf_level;
   logic [7:0] spi_rx;
   logic comp_hit, fifo_push;
   logic miso_s;

   assign wr = reg_strobe && reg_write;
   assign rd = reg_strobe && !reg_write;
   assign comp_hit = (reg_addr >= `TDCREG_OFF_COMP_LO) && (reg_addr <= `TDCREG_OFF_COMP_HI);
   assign comp_addr = {r_reg.page, reg_addr[8:1]};
   assign fifo_push = event_written && event_fifo_enable;
   assign evf_pop = rd && (reg_addr == `TDCREG_OFF_EVF_LO);
   // three flops; a change counts once the last two agree
   assign miso_s = (r_reg.sync_miso[1] == r_reg.sync_miso[2]) ? r_reg.sync_miso[2] : r_reg.miso_q;

   // ------------------------------
   // next state
   // ------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.clr = 1'b0;
      r_next.evrst = 1'b0;
      r_next.strig = 1'b0;
      r_next.push = 1'b0;
      r_next.cmd_valid = 1'b0;
      r_next.rd_taken = 1'b0;
      r_next.ack = 1'b0;
      r_next.sync_miso = {r_reg.sync_miso[1:0], flash_miso};
      r_next.miso_q = miso_s;
      spi_start = 1'b0;
      // clear beats a same-cycle trigger
      if (r_reg.clr) begin
         r_next.trig_cnt = 32'h0000_0000;
      end else if ((hw_trigger || r_reg.strig) && trigger_matching) begin
         r_next.trig_cnt = r_reg.trig_cnt + 32'h0000_0001;
      end
      // flash read ends with the byte
      if (r_reg.flash_wait && !spi_busy) begin
         r_next.flash_wait = 1'b0;
         r_next.ack = 1'b1;
         r_next.rdata = {8'h00, spi_rx};
      end
      if (wr) begin
         r_next.ack = 1'b1;
         unique case (reg_addr)
            `TDCREG_OFF_SW_CLEAR: r_next.clr = 1'b1;
            `TDCREG_OFF_EV_RESET: r_next.evrst = 1'b1;
            `TDCREG_OFF_SW_TRIG: r_next.strig = 1'b1;
            `TDCREG_OFF_THRESH: begin
               // values beyond the buffer depth saturate
               r_next.thresh = (reg_wdata > {1'b0, `TDCREG_MAX_THRESH}) ?
                  `TDCREG_MAX_THRESH : reg_wdata[14:0];
            end
            `TDCREG_OFF_BLT_NUM: r_next.blt = reg_wdata[7:0];
            `TDCREG_OFF_TEST_HI: r_next.test_hi = reg_wdata;
            `TDCREG_OFF_TEST_LO: begin
               r_next.push_data = {r_reg.test_hi, reg_wdata};
               r_next.push = test_fifo_enable;
            end
            `TDCREG_OFF_OUT_SEL: r_next.out_sel = reg_wdata;
            `TDCREG_OFF_MICRO: begin
               if (command_write_allowed) begin
                  r_next.micro = reg_wdata;
                  r_next.cmd_valid = 1'b1;
               end
            end
            `TDCREG_OFF_FLASH_CS: r_next.cs_n = reg_wdata[0];
            `TDCREG_OFF_FLASH_DATA: begin
               // write ack is immediate; a flash data write while the byte runs starts nothing
               spi_start = 1'b1;
            end
            `TDCREG_OFF_COMP_PAGE: r_next.page = reg_wdata[7:0];
            `TDCREG_OFF_SCRATCH_HI: r_next.scratch_hi = reg_wdata;
            `TDCREG_OFF_SCRATCH_LO: r_next.scratch_lo = reg_wdata;
            `TDCREG_OFF_SCRATCH_N: r_next.scratch_n = reg_wdata;
            default: ;
         endcase
      end else if (rd) begin
         r_next.ack = 1'b1;
         r_next.rdata = 16'h0000;
         if (comp_hit) begin
            r_next.rdata = read_comp_enable ? comp_rdata : 16'h0000;
         end else begin
            unique case (reg_addr)
               `TDCREG_OFF_TRIG_CNT_HI: r_next.rdata = r_reg.trig_cnt[31:16];
               `TDCREG_OFF_TRIG_CNT_LO: r_next.rdata = r_reg.trig_cnt[15:0];
               `TDCREG_OFF_EV_STORED: r_next.rdata = buffer_event_count;
               `TDCREG_OFF_THRESH: r_next.rdata = {1'b0, r_reg.thresh};
               `TDCREG_OFF_BLT_NUM: r_next.rdata = {8'h00, r_reg.blt};
               `TDCREG_OFF_FW_REV: r_next.rdata = {8'h00, FW_REVISION};
               `TDCREG_OFF_TEST_HI: r_next.rdata = r_reg.test_hi;
               `TDCREG_OFF_TEST_LO: r_next.rdata = r_reg.push_data[15:0];
               `TDCREG_OFF_OUT_SEL: r_next.rdata = r_reg.out_sel;
               `TDCREG_OFF_MICRO: begin
                  if (command_read_allowed) begin
                     r_next.rdata = micro_reply;
                     r_next.rd_taken = 1'b1;
                  end
               end
               `TDCREG_OFF_MICRO_HS: begin
                  r_next.rdata[`TDCREG_BIT_HS_READ] = command_read_allowed;
                  r_next.rdata[`TDCREG_BIT_HS_WRITE] = command_write_allowed;
               end
               `TDCREG_OFF_FLASH_CS: r_next.rdata = {15'h0000, r_reg.cs_n};
               `TDCREG_OFF_FLASH_DATA: begin
                  spi_start = 1'b1;
                  r_next.ack = 1'b0;
                  r_next.flash_wait = 1'b1;
               end
               `TDCREG_OFF_COMP_PAGE: r_next.rdata = {8'h00, r_reg.page};
               `TDCREG_OFF_EVF_HI: begin
                  // low half held so its pop stays coherent
                  r_next.rdata = evf_head[31:16];
                  r_next.evf_lo_hold = evf_head[15:0];
               end
               `TDCREG_OFF_EVF_LO: r_next.rdata = r_reg.evf_lo_hold;
               `TDCREG_OFF_EVF_LEVEL: r_next.rdata = 16'(evf_level);
               `TDCREG_OFF_EVF_FLAGS: begin
                  r_next.rdata[`TDCREG_BIT_EVF_READY] = !evf_empty;
                  r_next.rdata[`TDCREG_BIT_EVF_FULL] = evf_full;
               end
               `TDCREG_OFF_SCRATCH_HI: r_next.rdata = r_reg.scratch_hi;
               `TDCREG_OFF_SCRATCH_LO: r_next.rdata = r_reg.scratch_lo;
               `TDCREG_OFF_SCRATCH_N: r_next.rdata = r_reg.scratch_n;
               default: ;
            endcase
         end
      end
   end

   // ------------------------------
   // registers
   // ------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         r_reg <= '0;
         r_reg.thresh <= `TDCREG_RST_THRESH;
         r_reg.blt <= `TDCREG_RST_BLT;
         r_reg.cs_n <= `TDCREG_RST_CS;
         r_reg.page <= `TDCREG_RST_PAGE;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   // ------------------------------
   // helpers
   // ------------------------------
   tdcreg_spi_byte u_spi (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .start(spi_start && !spi_busy),
      .tx_byte(reg_wdata[7:0]),
      .miso(miso_s),
      .busy(spi_busy),
      .sck(flash_sck),
      .mosi(flash_mosi),
      .rx_byte(spi_rx)
   );

   // a clear also flushes the fifo
   tdcreg_event_fifo #(.WIDTH(32), .DEPTH_LOG2(FIFO_LOG2)) u_evf (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .flush(r_reg.clr),
      .push(fifo_push),
      .push_data({r_reg.trig_cnt[15:0], event_word_count}),
      .pop(evf_pop),
      .head(evf_head),
      .level(evf_level),
      .empty(evf_empty),
      .full(evf_full)
   );

   // ------------------------------
   // outputs
   // ------------------------------
   assign tdc_clear = r_reg.clr;
   assign tdc_global_reset = r_reg.clr;
   assign buffer_clear = r_reg.clr;
   assign tdc_event_reset = r_reg.evrst;
   assign trigger = hw_trigger || r_reg.strig;
   assign buffer_push = r_reg.push;
   assign buffer_push_data = r_reg.push_data;
   assign converter_data_block = test_fifo_enable;
   assign almost_full = (buffer_word_count >= {1'b0, r_reg.thresh});
   assign board_full = buffer_full || (event_fifo_enable && evf_full);
   assign events_per_block = r_reg.blt;
   assign out_select = r_reg.out_sel;
   assign micro_cmd_data = r_reg.micro;
   assign micro_cmd_valid = r_reg.cmd_valid;
   assign micro_read_taken = r_reg.rd_taken;
   assign flash_cs_n = r_reg.cs_n;
   assign flash_busy = spi_busy || r_reg.flash_wait;
   assign reg_rdata = r_reg.rdata;
   assign reg_ack = r_reg.ack;
endmodule

// ==== verification/tdcreg_properties.sv ====
// port assertions for the control bank
// assumes binding onto tdcreg_top with ce held high
`timescale 1ns/10ps
module tdcreg_properties (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic reg_strobe,
   input wire logic reg_write,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic hw_trigger,
   input wire logic buffer_full,
   input wire logic test_fifo_enable,
   input wire logic command_write_allowed,
   input wire logic tdc_clear,
   input wire logic buffer_clear,
   input wire logic tdc_global_reset,
   input wire logic tdc_event_reset,
   input wire logic trigger,
   input wire logic micro_cmd_valid,
   input wire logic [15:0] micro_cmd_data,
   input wire logic converter_data_block,
   input wire logic board_full,
   input wire logic flash_cs_n,
   input wire logic flash_busy,
   input wire logic [15:0] comp_addr
);
   // ----------------------------------------
   // access decode
   // ----------------------------------------
   wire logic wr = reg_strobe && reg_write && ce;
   wire logic w_clr = wr && reg_addr == 16'h1016;
   wire logic w_mic = wr && reg_addr == 16'h102E;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_fl_go;
      wr && reg_addr == 16'h1034 && !flash_busy;
   endsequence
   // byte exchange must finish, not hang busy
   sequence s_fl_run;
      ##[0:3] flash_busy ##[1:60] !flash_busy;
   endsequence
   property p_clear;
      w_clr |=> tdc_clear && buffer_clear && tdc_global_reset;
   endproperty
   property p_evres;
      wr && reg_addr == 16'h1018 |=> tdc_event_reset;
   endproperty
   property p_strig;
      wr && reg_addr == 16'h101A |=> trigger;
   endproperty
   property p_htrig;
      hw_trigger |-> trigger;
   endproperty
   property p_once;
      tdc_clear |-> $past(w_clr);
   endproperty
   property p_micro;
      w_mic && command_write_allowed |=> micro_cmd_valid && micro_cmd_data == $past(reg_wdata);
   endproperty
   property p_mgate;
      w_mic && !command_write_allowed |=> !micro_cmd_valid;
   endproperty
   property p_flash;
      s_fl_go |=> s_fl_run;
   endproperty
   property p_block;
      converter_data_block == test_fifo_enable;
   endproperty
   property p_full;
      buffer_full |-> board_full;
   endproperty
   property p_comp;
      wr && reg_addr == 16'h1036 |=> comp_addr == {$past(reg_wdata[7:0]), reg_addr[8:1]};
   endproperty
   property p_cs;
      $fell(reset) |-> flash_cs_n;
   endproperty
   a_clear: assert property (p_clear) else $error("clear write gave no pulses");
   a_evres: assert property (p_evres) else $error("event reset missing");
   a_strig: assert property (p_strig) else $error("soft trigger missing");
   a_htrig: assert property (p_htrig) else $error("hw trigger not passed");
   a_once: assert property (p_once) else $error("clear pulse without write");
   a_micro: assert property (p_micro) else $error("opcode not passed");
   a_mgate: assert property (p_mgate) else $error("opcode passed while barred");
   a_flash: assert property (p_flash) else $error("flash byte not run");
   a_block: assert property (p_block) else $error("converter block wrong");
   a_full: assert property (p_full) else $error("board full missing");
   a_comp: assert property (p_comp) else $error("window address wrong");
   a_cs: assert property (p_cs) else $error("select not idle at reset");
endmodule
bind tdcreg_top tdcreg_properties tdcreg_properties_i (.*);

// ==== verification/tdcreg_flash_model.sv ====
// serial flash stand-in: records the last byte in, answers a fixed byte
// assumes data out on sck fall, sampled on sck rise, msb first
`timescale 1ns/10ps
module tdcreg_flash_model #(
   parameter logic [7:0] REPLY = 8'h3C
) (
   input wire logic flash_cs_n,
   input wire logic flash_sck,
   input wire logic flash_mosi,
   output logic flash_miso,
   output logic [7:0] got_byte
);
   logic [7:0] sh = 8'h00;
   logic [2:0] n = 3'h0;
   initial flash_miso = 1'b1;
   initial got_byte = 8'h00;
   // released line has no pull: show a flipped value, never a stale one
   always @(flash_cs_n) begin
      n = 3'h0;
      flash_miso = flash_cs_n ? ~flash_miso : REPLY[7];
   end
   always @(posedge flash_sck) begin
      if (!flash_cs_n) begin
         sh = {sh[6:0], flash_mosi};
         n = n + 3'h1;
         if (n == 3'h0) begin
            got_byte = sh;
            flash_miso = REPLY[7];
         end
      end
   end
   always @(negedge flash_sck) begin
      if (!flash_cs_n) begin
         flash_miso = REPLY[3'h7 - n];
      end
   end
endmodule

// ==== verification/tdcreg_top_tb_top.sv ====
// self-checking bench for the control bank
// assumes the flash stand-in and the bound checker
`timescale 1ns/10ps
module tdcreg_top_tb_top;
   logic clk = 1'b0, reset = 1'b1, ce = 1'b1, reg_strobe = 1'b0, reg_write = 1'b0;
   logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata, rd_val;
   logic reg_ack, trigger_matching = 1'b0, test_fifo_enable = 1'b0, read_comp_enable = 1'b0;
   logic event_fifo_enable = 1'b0, resolution_100ps = 1'b0, hw_trigger = 1'b0;
   logic [15:0] buffer_word_count = 16'h0, buffer_event_count = 16'h0;
   logic [15:0] event_word_count = 16'h0, micro_reply = 16'hBEEF;
   logic buffer_full = 1'b0, event_written = 1'b0, command_read_allowed = 1'b0;
   logic command_write_allowed = 1'b0, flash_miso, flash_cs_n, flash_sck, flash_mosi;
   logic flash_busy, tdc_clear, tdc_global_reset, buffer_clear, tdc_event_reset, trigger;
   logic buffer_push, converter_data_block, almost_full, board_full;
   logic micro_cmd_valid, micro_read_taken;
   logic [31:0] buffer_push_data, pushed = 32'h0;
   logic [7:0] events_per_block, got_byte;
   logic [15:0] out_select, micro_cmd_data, comp_addr, comp_rdata;
   int fails = 0;
   int comparisons = 0;
   assign comp_rdata = comp_addr ^ 16'h5A5A;
   tdcreg_top #(.FIFO_LOG2(4)) tdcreg_top_i (.*);
   tdcreg_flash_model tdcreg_flash_model_i (.*);
   initial forever #25 clk = ~clk;
   always @(posedge clk) if (buffer_push === 1'b1) pushed <= buffer_push_data;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // flash accesses must not overlap a running byte
   task automatic idle;
      int n;
      n = 0;
      while (flash_busy !== 1'b0 && n < 100) begin
         tick;
         n++;
      end
      if (n == 100) chk(1, 0);
   endtask
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      idle;
      tick;
      reg_strobe = 1'b1;
      reg_write = w;
      reg_addr = a;
      reg_wdata = d;
      tick;
      reg_strobe = 1'b0;
      while (reg_ack !== 1'b1 && n < 80) begin
         tick;
         n++;
      end
      if (n == 80) chk(2, 0);
      rd_val = reg_rdata;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      acc(1'b0, a, 16'h0000);
      chk(rd_val, e);
   endtask
   task automatic pulse(input logic h, input logic [15:0] c);
      tick;
      hw_trigger = h;
      event_written = !h;
      event_word_count = c;
      tick;
      hw_trigger = 1'b0;
      event_written = 1'b0;
   endtask
   task automatic results;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      #(20000 * 50);
      fails++;
      $display("mismatch at %0t: timeout", $time);
      results;
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 reset = 1'b0;
      rd(16'h1022, 16'h40);
      rd(16'h1024, 16'h0);
      rd(16'h1036, 16'h0);
      rd(16'h1032, 16'h1);
      rd(16'h1026, 16'h12);
      rd(16'h103E, 16'h0);
      rd(16'h1100, 16'h0);
      $display("test reset_values done");
      wr(16'h1022, 16'h7FDF);
      rd(16'h1022, 16'h7FDF);
      buffer_word_count = 16'h7FDE;
      tick;
      chk(almost_full, 0);
      buffer_word_count = 16'h7FDF;
      tick;
      chk(almost_full, 1);
      wr(16'h1022, 16'hFFFF);
      rd(16'h1022, 16'h7FDF);
      wr(16'h1024, 16'h00FF);
      rd(16'h1024, 16'h00FF);
      chk(events_per_block, 8'hFF);
      buffer_event_count = 16'h0123;
      rd(16'h1020, 16'h0123);
      $display("test thresholds done");
      trigger_matching = 1'b1;
      pulse(1'b1, 16'h0);
      pulse(1'b1, 16'h0);
      wr(16'h101A, 16'hFFFF);
      wr(16'h1018, 16'h0000);
      rd(16'h101C, 16'h0000);
      rd(16'h101E, 16'h0003);
      trigger_matching = 1'b0;
      pulse(1'b1, 16'h0);
      rd(16'h101E, 16'h0003);
      wr(16'h1016, 16'h5555);
      rd(16'h101E, 16'h0000);
      $display("test counting done");
      test_fifo_enable = 1'b1;
      wr(16'h1028, 16'hABCD);
      wr(16'h102A, 16'h1234);
      tick;
      chk(pushed, 32'hABCD1234);
      test_fifo_enable = 1'b0;
      command_write_allowed = 1'b1;
      command_read_allowed = 1'b1;
      wr(16'h102E, 16'h0A5A);
      chk(micro_cmd_data, 16'h0A5A);
      rd(16'h1030, 16'h0003);
      rd(16'h102E, 16'hBEEF);
      chk(micro_read_taken, 1);
      command_read_allowed = 1'b0;
      command_write_allowed = 1'b0;
      rd(16'h102E, 16'h0000);
      wr(16'h102E, 16'h1111);
      chk(micro_cmd_data, 16'h0A5A);
      $display("test test_and_micro done");
      wr(16'h1032, 16'h0000);
      chk(flash_cs_n, 0);
      wr(16'h1034, 16'h00A5);
      idle;
      chk(got_byte, 8'hA5);
      rd(16'h1034, 16'h003C);
      wr(16'h1032, 16'h0001);
      chk(flash_cs_n, 1);
      read_comp_enable = 1'b1;
      wr(16'h1036, 16'h0003);
      rd(16'h1036, 16'h0003);
      rd(16'h8004, 16'h0302 ^ 16'h5A5A);
      rd(16'h81FE, 16'h03FF ^ 16'h5A5A);
      $display("test flash_and_window done");
      event_fifo_enable = 1'b1;
      trigger_matching = 1'b1;
      wr(16'h1016, 16'h0000);
      pulse(1'b1, 16'h0);
      pulse(1'b0, 16'h0007);
      rd(16'h103C, 16'h1);
      rd(16'h103E, 16'h1);
      rd(16'h1038, 16'h1);
      rd(16'h103A, 16'h7);
      rd(16'h103E, 16'h0);
      chk(board_full, 0);
      for (int i = 0; i < 16; i++) pulse(1'b0, 16'(i));
      rd(16'h103C, 16'h0010);
      rd(16'h103E, 16'h0003);
      chk(board_full, 1);
      buffer_full = 1'b1;
      tick;
      $display("test event_fifo done");
      results;
   end
endmodule
